// >>> verilog/bringup_defs.vh
// Purpose: Constants for the converter bring-up sequencer.
// Assumes: Host reaches device fields by a field code over a simple access port.
// Notes:   Functional notes follow.
// Functional notes
// - Straps synth enable and reference select beforehand
// - Power-down pin held low always
// - Stable clock before issuing software reset
// - Poll init-complete until it reads one
// - Synth reset first, skip if bypassed
// - Write oscillator bias 0x4A during reset
// - Program P, V and N dividers
// - Auto calibration enable or manual trim
// - Release synth reset, starts trim calibration
// - Link disable before link setting changes
// - Calibration disable before calibration changes
// - Multiframe field is frames minus one
// - Choose sync source: single-ended or timestamp
// - Confirm osc cal done and lock first
// - Re-enable calibration before the link
// - Re-enable link to restart link machine
// - Software trigger written zero then one
// - Pin trigger enable, pin low then high
// - SYNC used only in 8B/10B formats
// - Data valid after receiver init and calibration
`ifndef BRINGUP_DEFS_VH
`define BRINGUP_DEFS_VH

`define FLD_W            6
`define DAT_W            16
`define F_SOFT_RESET     6'h01
`define F_INIT_DONE      6'h02
`define F_SYNTH_RESET    6'h03
`define F_OSC_BIAS       6'h04
`define F_P_DIV          6'h05
`define F_V_DIV          6'h06
`define F_N_DIV          6'h07
`define F_OSC_CAL_EN     6'h08
`define F_OSC_TRIM       6'h09
`define F_OSC_CAL_DONE   6'h0A
`define F_SYNTH_LOCK     6'h0B
`define F_LINK_EN        6'h0C
`define F_CAL_EN         6'h0D
`define F_LINK_FORMAT    6'h0E
`define F_MF_LEN_M1      6'h0F
`define F_SYNC_SEL       6'h10
`define F_CAL_CFG        6'h11
`define F_SW_CAL_TRIG    6'h12
`define F_PIN_TRIG_EN    6'h13
`define F_FOREGROUND_DONE_BIT        6'h14
`define OSC_BIAS_VAL     16'h004A
`define CLK_PERIOD_NS    25
`define TRIG_LOW_NS      200
`define TRIG_LOW_CYC     ((`TRIG_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_W           64
`define FIFO_D           32

`endif

// >>> verilog/bringup_sequencer.v
// Purpose: Host-side bring-up sequencer for a quad converter with serial link.
// Assumes: Device field access port answers on the same clock with dev_ack.
// Notes:   Sample data passes a 32-word FIFO, admitted only once data is valid.
`timescale 1ns/1ps
`include "bringup_defs.vh"

module sample_fifo #(
   parameter W = 64,
   parameter D = 32,
   parameter A = 5
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output reg  [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1];
   reg [A-1:0] wptr_r;
   reg [A-1:0] rptr_r;
   reg [A:0]   count_r;
   reg         oval_r;
   wire        push;
   wire        pop;
   wire        load;

   // Output register counts toward the depth, so D words in all
   assign in_ready  = ((count_r + {{A{1'b0}}, oval_r}) != D[A:0]);
   assign push      = in_valid && in_ready;
   // Output register refills whenever words wait and it is empty or being taken
   assign load      = (count_r != {(A+1){1'b0}}) && (!oval_r || out_ready);
   assign pop       = load;
   assign out_valid = oval_r;

   always @(posedge clk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r   <= {A{1'b0}};
         rptr_r   <= {A{1'b0}};
         count_r  <= {(A+1){1'b0}};
         oval_r   <= 1'b0;
         out_data <= {W{1'b0}};
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r   <= rptr_r + 1'b1;
            out_data <= mem[rptr_r];
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
         if (load) begin
            oval_r <= 1'b1;
         end else if (out_ready) begin
            oval_r <= 1'b0;
         end
      end
   end
endmodule // sample_fifo

module bringup_sequencer (
   input  wire                 sys_clk,
   input  wire                 arst_n,
   input  wire                 start,
   input  wire                 use_synth,
   input  wire                 use_se_ref,
   input  wire [`DAT_W-1:0]    p_div,
   input  wire [`DAT_W-1:0]    v_div,
   input  wire [`DAT_W-1:0]    n_div,
   input  wire                 auto_osc_cal,
   input  wire [`DAT_W-1:0]    osc_trim_value,
   input  wire [`DAT_W-1:0]    link_format_select,
   input  wire                 format_is_8b10b,
   input  wire [`DAT_W-1:0]    multiframe_len_minus_one,
   input  wire                 sync_from_timestamp,
   input  wire [`DAT_W-1:0]    cal_cfg,
   input  wire                 fg_cal_wanted,
   input  wire                 trigger_by_pin,
   output reg                  busy,
   output reg                  done,
   output reg  [4:0]           step,
   output reg                  synth_enable_strap,
   output reg                  single_ended_ref_select,
   output reg                  power_down_pin,
   output reg                  cal_trigger_pin,
   input  wire                 clk_stable_in,
   input  wire                 cal_status_pin,
   output wire                 dev_req,
   output wire                 dev_we,
   output wire [`FLD_W-1:0]    dev_field,
   output wire [`DAT_W-1:0]    dev_wdata,
   input  wire                 dev_ack,
   input  wire [`DAT_W-1:0]    dev_rdata,
   input  wire                 rx_init_done,
   input  wire                 rx_valid,
   output wire                 rx_ready,
   input  wire [`FIFO_W-1:0]   rx_data,
   output wire                 out_valid,
   input  wire                 out_ready,
   output wire [`FIFO_W-1:0]   out_data,
   output reg                  data_valid
);
   localparam S_IDLE      = 5'd0;
   localparam S_CLKWAIT   = 5'd1;
   localparam S_SRESET    = 5'd2;
   localparam S_POLLINIT  = 5'd3;
   localparam S_SYNRST1   = 5'd4;
   localparam S_BIAS      = 5'd5;
   localparam S_PDIV      = 5'd6;
   localparam S_VDIV      = 5'd7;
   localparam S_NDIV      = 5'd8;
   localparam S_CALEN     = 5'd9;
   localparam S_TRIM      = 5'd10;
   localparam S_SYNRST0   = 5'd11;
   localparam S_LINKOFF   = 5'd12;
   localparam S_CALOFF    = 5'd13;
   localparam S_FORMAT    = 5'd14;
   localparam S_MFLEN     = 5'd15;
   localparam S_SYNCSEL   = 5'd16;
   localparam S_CALCFG    = 5'd17;
   localparam S_POLLOSC   = 5'd18;
   localparam S_POLLLOCK  = 5'd19;
   localparam S_CALON     = 5'd20;
   localparam S_LINKON    = 5'd21;
   localparam S_TRIG0     = 5'd22;
   localparam S_TRIG1     = 5'd23;
   localparam S_PINEN     = 5'd24;
   localparam S_PINLOW    = 5'd25;
   localparam S_CALWAIT   = 5'd26;
   localparam S_DONE      = 5'd27;

   reg                 rst_m_r;
   reg                 rst_n_r;
   reg  [2:0]          clk_ok_sh_r;
   reg                 clk_ok_r;
   reg  [2:0]          cstat_sh_r;
   reg                 cstat_r;
   reg  [4:0]          state_r;
   reg  [4:0]          state_nxt;
   reg                 req_r;
   reg  [7:0]          low_cnt_r;
   reg                 foreground_done_bit_r;
   reg                 we_c;
   reg  [`FLD_W-1:0]   fld_c;
   reg  [`DAT_W-1:0]   wd_c;
   wire                rst_n;
   wire                poll_ok;

   assign rst_n = rst_n_r;

   // Reset release through two flops
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n_r <= rst_m_r;
      end
   end

   // Board pins: three flops, accept when last two agree
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_ok_sh_r <= 3'h0;
         clk_ok_r    <= 1'b0;
         cstat_sh_r  <= 3'h0;
         cstat_r     <= 1'b0;
      end else begin
         clk_ok_sh_r <= {clk_ok_sh_r[1:0], clk_stable_in};
         cstat_sh_r  <= {cstat_sh_r[1:0], cal_status_pin};
         if (clk_ok_sh_r[1] == clk_ok_sh_r[2]) begin
            clk_ok_r <= clk_ok_sh_r[2];
         end
         if (cstat_sh_r[1] == cstat_sh_r[2]) begin
            cstat_r <= cstat_sh_r[2];
         end
      end
   end

   // Field access per step; reads are polls of a one-bit flag
   always @* begin
      we_c  = 1'b1;
      fld_c = {`FLD_W{1'b0}};
      wd_c  = {`DAT_W{1'b0}};
      case (state_r)
         S_SRESET:   begin fld_c = `F_SOFT_RESET;  wd_c = 16'h0001; end
         S_POLLINIT: begin fld_c = `F_INIT_DONE;   we_c = 1'b0; end
         S_SYNRST1:  begin fld_c = `F_SYNTH_RESET; wd_c = 16'h0001; end
         S_BIAS:     begin fld_c = `F_OSC_BIAS;    wd_c = `OSC_BIAS_VAL; end
         S_PDIV:     begin fld_c = `F_P_DIV;       wd_c = p_div; end
         S_VDIV:     begin fld_c = `F_V_DIV;       wd_c = v_div; end
         S_NDIV:     begin fld_c = `F_N_DIV;       wd_c = n_div; end
         S_CALEN:    begin
            fld_c = `F_OSC_CAL_EN;
            wd_c  = {15'h0000, auto_osc_cal};
         end
         S_TRIM:     begin fld_c = `F_OSC_TRIM;    wd_c = osc_trim_value; end
         S_SYNRST0:  begin fld_c = `F_SYNTH_RESET; wd_c = 16'h0000; end
         S_LINKOFF:  begin fld_c = `F_LINK_EN;     wd_c = 16'h0000; end
         S_CALOFF:   begin fld_c = `F_CAL_EN;      wd_c = 16'h0000; end
         S_FORMAT:   begin fld_c = `F_LINK_FORMAT; wd_c = link_format_select; end
         S_MFLEN:    begin
            fld_c = `F_MF_LEN_M1;
            wd_c  = multiframe_len_minus_one;
         end
         S_SYNCSEL:  begin
            fld_c = `F_SYNC_SEL;
            wd_c  = {15'h0000, sync_from_timestamp};
         end
         S_CALCFG:   begin fld_c = `F_CAL_CFG;     wd_c = cal_cfg; end
         S_POLLOSC:  begin fld_c = `F_OSC_CAL_DONE; we_c = 1'b0; end
         S_POLLLOCK: begin fld_c = `F_SYNTH_LOCK;  we_c = 1'b0; end
         S_CALON:    begin fld_c = `F_CAL_EN;      wd_c = 16'h0001; end
         S_LINKON:   begin fld_c = `F_LINK_EN;     wd_c = 16'h0001; end
         S_TRIG0:    begin fld_c = `F_SW_CAL_TRIG; wd_c = 16'h0000; end
         S_TRIG1:    begin fld_c = `F_SW_CAL_TRIG; wd_c = 16'h0001; end
         S_PINEN:    begin fld_c = `F_PIN_TRIG_EN; wd_c = 16'h0001; end
         S_CALWAIT:  begin fld_c = `F_FOREGROUND_DONE_BIT;     we_c = 1'b0; end
         default:    begin we_c = 1'b0; end
      endcase
   end

   assign dev_req   = req_r;
   assign dev_we    = we_c;
   assign dev_field = fld_c;
   assign dev_wdata = wd_c;
   assign poll_ok   = dev_rdata[0];

   // Next step after the current access completes
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:     state_nxt = start ? S_CLKWAIT : S_IDLE;
         S_CLKWAIT:  state_nxt = clk_ok_r ? S_SRESET : S_CLKWAIT;
         S_SRESET:   state_nxt = S_POLLINIT;
         S_POLLINIT: state_nxt = poll_ok ? (use_synth ? S_SYNRST1 : S_LINKOFF)
                                         : S_POLLINIT;
         S_SYNRST1:  state_nxt = S_BIAS;
         S_BIAS:     state_nxt = S_PDIV;
         S_PDIV:     state_nxt = S_VDIV;
         S_VDIV:     state_nxt = S_NDIV;
         S_NDIV:     state_nxt = auto_osc_cal ? S_CALEN : S_TRIM;
         S_TRIM:     state_nxt = S_CALEN;
         S_CALEN:    state_nxt = S_SYNRST0;
         S_SYNRST0:  state_nxt = S_LINKOFF;
         S_LINKOFF:  state_nxt = S_CALOFF;
         S_CALOFF:   state_nxt = S_FORMAT;
         S_FORMAT:   state_nxt = format_is_8b10b ? S_MFLEN : S_SYNCSEL;
         S_MFLEN:    state_nxt = S_SYNCSEL;
         S_SYNCSEL:  state_nxt = S_CALCFG;
         S_CALCFG:   state_nxt = use_synth ? S_POLLOSC : S_CALON;
         S_POLLOSC:  state_nxt = poll_ok ? S_POLLLOCK : S_POLLOSC;
         S_POLLLOCK: state_nxt = poll_ok ? S_CALON : S_POLLLOCK;
         S_CALON:    state_nxt = S_LINKON;
         S_LINKON:   state_nxt = !fg_cal_wanted ? S_DONE
                                 : (trigger_by_pin ? S_PINEN : S_TRIG0);
         S_TRIG0:    state_nxt = S_TRIG1;
         S_TRIG1:    state_nxt = S_CALWAIT;
         S_PINEN:    state_nxt = S_PINLOW;
         S_PINLOW:   state_nxt = S_CALWAIT;
         S_CALWAIT:  state_nxt = S_DONE;
         S_DONE:     state_nxt = start ? S_CLKWAIT : S_DONE;
         default:    state_nxt = S_IDLE;
      endcase
   end

   // One access at a time, each acknowledged before the next
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r                 <= S_IDLE;
         req_r                   <= 1'b0;
         busy                    <= 1'b0;
         done                    <= 1'b0;
         step                    <= 5'd0;
         synth_enable_strap      <= 1'b0;
         single_ended_ref_select <= 1'b0;
         power_down_pin          <= 1'b0;
         cal_trigger_pin         <= 1'b1;
         low_cnt_r               <= 8'h00;
         foreground_done_bit_r               <= 1'b0;
      end else begin
         power_down_pin <= 1'b0;
         step           <= state_r;
         busy           <= (state_r != S_IDLE) && (state_r != S_DONE);
         done           <= (state_r == S_DONE);
         if ((state_r == S_IDLE) || (state_r == S_DONE)) begin
            // Straps follow the user only between bring-ups
            synth_enable_strap      <= use_synth;
            single_ended_ref_select <= use_se_ref && use_synth;
         end
         case (state_r)
            S_IDLE, S_DONE: begin
               req_r <= 1'b0;
               if (start) begin
                  foreground_done_bit_r <= 1'b0;
                  state_r   <= S_CLKWAIT;
               end
            end
            S_CLKWAIT: begin
               state_r <= state_nxt;
               req_r   <= clk_ok_r;
            end
            S_PINLOW: begin
               // Pin held low a minimum time, then driven high
               if (low_cnt_r < `TRIG_LOW_CYC) begin
                  cal_trigger_pin <= 1'b0;
                  low_cnt_r       <= low_cnt_r + 8'h01;
               end else begin
                  cal_trigger_pin <= 1'b1;
                  low_cnt_r       <= 8'h00;
                  state_r         <= S_CALWAIT;
                  req_r           <= 1'b1;
               end
            end
            S_CALWAIT: begin
               // Status pin or done bit counts; an open poll waits for its ack
               if ((cstat_r && !req_r)
                   || (req_r && dev_ack && (poll_ok || cstat_r))) begin
                  req_r     <= 1'b0;
                  foreground_done_bit_r <= 1'b1;
                  state_r   <= S_DONE;
               end else if (req_r && dev_ack) begin
                  req_r <= 1'b0;
               end else begin
                  req_r <= 1'b1;
               end
            end
            default: begin
               if (req_r && dev_ack) begin
                  req_r   <= 1'b0;
                  state_r <= state_nxt;
               end else if (!req_r) begin
                  req_r <= (state_r != S_PINLOW);
               end
            end
         endcase
      end
   end

   // Data valid needs receiver init and finished calibration
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_valid <= 1'b0;
      end else begin
         data_valid <= rx_init_done && (state_r == S_DONE)
                       && (foreground_done_bit_r || !fg_cal_wanted);
      end
   end

   wire fifo_in_ready;

   // Samples held back until valid; full FIFO stalls the receiver
   assign rx_ready = data_valid && fifo_in_ready;

   sample_fifo #(
      .W (`FIFO_W),
      .D (`FIFO_D),
      .A (5)
   ) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (rx_valid && data_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_data),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );
endmodule // bringup_sequencer

// >>> testbench/bringup_sequencer_sva.sv
// Purpose: Port-level checks of the bring-up sequencer.
// Assumes: Field codes from the shared defines.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
`include "bringup_defs.vh"
module bringup_sequencer_sva (
   input wire              sys_clk,
   input wire              arst_n,
   input wire              use_synth,
   input wire              format_is_8b10b,
   input wire [`DAT_W-1:0] multiframe_len_minus_one,
   input wire              clk_stable_in,
   input wire              synth_enable_strap,
   input wire              single_ended_ref_select,
   input wire              power_down_pin,
   input wire              cal_trigger_pin,
   input wire              dev_req,
   input wire              dev_we,
   input wire [`FLD_W-1:0] dev_field,
   input wire [`DAT_W-1:0] dev_wdata,
   input wire              dev_ack,
   input wire              rx_ready,
   input wire              data_valid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire wr = dev_req && dev_we;
   a_pd_low: assert property (power_down_pin == 1'b0)
      else $error("power down pin high");
   a_ref_needs_synth: assert property (single_ended_ref_select |-> synth_enable_strap)
      else $error("ref select without synth");
   a_req_holds: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_field)
      && $stable(dev_wdata) && $stable(dev_we)) else $error("access changed before ack");
   a_gap_after_ack: assert property (dev_req && dev_ack |=> !dev_req)
      else $error("no gap after ack");
   a_trig_low_len: assert property ($fell(cal_trigger_pin) |=>
      !cal_trigger_pin [*7] ##1 cal_trigger_pin) else $error("trigger pulse length");
   a_bias_value: assert property (wr && dev_field == `F_OSC_BIAS |-> dev_wdata == 16'h004A)
      else $error("bias value");
   a_mflen_only_8b: assert property (dev_req && dev_field == `F_MF_LEN_M1 |->
      format_is_8b10b && dev_wdata == multiframe_len_minus_one) else $error("multiframe");
   a_synth_skip: assert property (dev_req && dev_field == `F_SYNTH_RESET |-> use_synth)
      else $error("synth access while bypassed");
   a_reset_clk_first: assert property (wr && dev_field == `F_SOFT_RESET |-> clk_stable_in)
      else $error("soft reset before clock");
   a_rx_gate: assert property (rx_ready |-> data_valid)
      else $error("stream open before data valid");
   c_sw_trig: cover property (wr && dev_field == `F_SW_CAL_TRIG);
   c_pin_trig: cover property ($fell(cal_trigger_pin));
   c_valid: cover property ($rose(data_valid));
endmodule // bringup_sequencer_sva
bind bringup_sequencer bringup_sequencer_sva i_sva (.sys_clk(sys_clk), .arst_n(arst_n),
   .use_synth(use_synth), .format_is_8b10b(format_is_8b10b),
   .multiframe_len_minus_one(multiframe_len_minus_one), .clk_stable_in(clk_stable_in),
   .synth_enable_strap(synth_enable_strap), .single_ended_ref_select(single_ended_ref_select),
   .power_down_pin(power_down_pin), .cal_trigger_pin(cal_trigger_pin), .dev_req(dev_req),
   .dev_we(dev_we), .dev_field(dev_field), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
   .rx_ready(rx_ready), .data_valid(data_valid));

// >>> testbench/device_model.sv
// Purpose: Behavioural converter field store and calibration flags.
// Assumes: One access at a time, ack after ack_dly extra cycles.
// Notes:   Init flag reads 0 three times after soft reset.
`timescale 1ns/1ps
`include "bringup_defs.vh"
module device_model (
   input  wire              sys_clk,
   input  wire [3:0]        ack_dly,
   input  wire              dev_req,
   input  wire              dev_we,
   input  wire [`FLD_W-1:0] dev_field,
   input  wire [`DAT_W-1:0] dev_wdata,
   input  wire              cal_trigger_pin,
   output reg               dev_ack,
   output reg  [`DAT_W-1:0] dev_rdata,
   output reg               cal_status_pin
);
   reg [`DAT_W-1:0] fld [0:63];
   reg [3:0]        cnt;
   reg [1:0]        init_cnt;
   reg              pin_low;
   integer          i;
   initial begin
      for (i = 0; i < 64; i = i + 1) fld[i] = 16'h0000;
      {dev_ack, dev_rdata, cal_status_pin, cnt, init_cnt, pin_low} = 0;
   end
   always @(posedge sys_clk) begin
      dev_ack <= 1'b0;
      dev_rdata <= ~dev_rdata; // Idle data toggles, never holds the last answer
      pin_low <= !cal_trigger_pin;
      if (pin_low && cal_trigger_pin && fld[`F_PIN_TRIG_EN][0]) begin
         fld[`F_FOREGROUND_DONE_BIT] <= 16'h0001;
         cal_status_pin <= 1'b1;
      end
      if (dev_req && !dev_ack) begin
         if (cnt != ack_dly) cnt <= cnt + 4'h1;
         else begin
            cnt <= 4'h0;
            dev_ack <= 1'b1;
            if (dev_we) begin
               fld[dev_field] <= dev_wdata;
               case (dev_field)
                  `F_SOFT_RESET: begin
                     init_cnt <= 2'h3;
                     {fld[`F_FOREGROUND_DONE_BIT], fld[`F_OSC_CAL_DONE], fld[`F_SYNTH_LOCK]} <= 0;
                     fld[`F_SW_CAL_TRIG] <= 16'h0001;
                     cal_status_pin <= 1'b0;
                  end
                  `F_SYNTH_RESET: if (!dev_wdata[0]) begin
                     fld[`F_OSC_CAL_DONE] <= 16'h0001;
                     fld[`F_SYNTH_LOCK] <= 16'h0001;
                  end
                  `F_SW_CAL_TRIG: if (dev_wdata[0] && !fld[`F_SW_CAL_TRIG][0]) begin
                     fld[`F_FOREGROUND_DONE_BIT] <= 16'h0001;
                     cal_status_pin <= 1'b1;
                  end
                  default: ;
               endcase
            end else if (dev_field == `F_INIT_DONE) begin
               dev_rdata <= {15'h0000, init_cnt == 2'h0};
               if (init_cnt != 2'h0) init_cnt <= init_cnt - 2'h1;
            end else dev_rdata <= fld[dev_field];
         end
      end
   end
endmodule // device_model

// >>> testbench/bringup_sequencer_tb.sv
// Purpose: Self-checking bench for the bring-up sequencer.
// Assumes: Device model answers the field port.
// Notes:   Write order is logged and compared whole.
`timescale 1ns/1ps
`include "bringup_defs.vh"
module bringup_sequencer_tb;
   reg sys_clk = 0, arst_n = 0, start = 0, use_synth = 0, auto_osc_cal = 0, b8 = 0;
   reg ts = 0, pin = 0, clk_stable_in = 0, rx_init_done = 0, rx_valid = 0, out_ready = 0;
   reg [3:0] ack_dly = 0;
   reg se = 1, fg = 1;
   reg [15:0] trim = 16'h0123, mfl = 16'h001F;
   reg [63:0] rx_data = 0;
   wire busy, done, synth_enable_strap, single_ended_ref_select, power_down_pin;
   wire cal_trigger_pin, cal_status_pin, dev_req, dev_we, dev_ack, rx_ready, out_valid;
   wire data_valid;
   wire [4:0] step;
   wire [5:0] dev_field;
   wire [15:0] dev_wdata, dev_rdata;
   wire [63:0] out_data;
   integer mismatches = 0, cmp_count = 0;
   reg [21:0] wlog[$], exp_q[$];
   always #12.5 sys_clk = ~sys_clk;
   bringup_sequencer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
      .use_synth(use_synth), .use_se_ref(se), .p_div(16'h0002), .v_div(16'h0004),
      .n_div(16'h0014), .auto_osc_cal(auto_osc_cal), .osc_trim_value(trim),
      .link_format_select(16'h0008), .format_is_8b10b(b8),
      .multiframe_len_minus_one(mfl), .sync_from_timestamp(ts), .cal_cfg(16'h0005),
      .fg_cal_wanted(fg), .trigger_by_pin(pin), .busy(busy), .done(done), .step(step),
      .synth_enable_strap(synth_enable_strap), .power_down_pin(power_down_pin),
      .single_ended_ref_select(single_ended_ref_select), .cal_trigger_pin(cal_trigger_pin),
      .clk_stable_in(clk_stable_in), .cal_status_pin(cal_status_pin), .dev_req(dev_req),
      .dev_we(dev_we), .dev_field(dev_field), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata), .rx_init_done(rx_init_done), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .data_valid(data_valid));
   device_model i_dev (.sys_clk(sys_clk), .ack_dly(ack_dly), .dev_req(dev_req),
      .dev_we(dev_we), .dev_field(dev_field), .dev_wdata(dev_wdata),
      .cal_trigger_pin(cal_trigger_pin), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
      .cal_status_pin(cal_status_pin));
   always @(posedge sys_clk) if (dev_req && dev_ack && dev_we) wlog.push_back({dev_field, dev_wdata});
   task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task complete_run;
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task launch(input s, input a, input e, input p, input t, input [3:0] d);
      wlog.delete();
      exp_q.delete();
      @(posedge sys_clk) {use_synth, auto_osc_cal, b8, pin, ts, ack_dly} <= {s, a, e, p, t, d};
      @(posedge sys_clk) start <= 1'b1;
      @(posedge sys_clk) start <= 1'b0;
      exp_q.push_back({`F_SOFT_RESET, 16'h0001});
      if (s) begin
         exp_q.push_back({`F_SYNTH_RESET, 16'h0001});
         exp_q.push_back({`F_OSC_BIAS, 16'h004A});
         exp_q.push_back({`F_P_DIV, 16'h0002});
         exp_q.push_back({`F_V_DIV, 16'h0004});
         exp_q.push_back({`F_N_DIV, 16'h0014});
         if (!a) exp_q.push_back({`F_OSC_TRIM, trim});
         exp_q.push_back({`F_OSC_CAL_EN, 15'h0000, a});
         exp_q.push_back({`F_SYNTH_RESET, 16'h0000});
      end
      exp_q.push_back({`F_LINK_EN, 16'h0000});
      exp_q.push_back({`F_CAL_EN, 16'h0000});
      exp_q.push_back({`F_LINK_FORMAT, 16'h0008});
      if (e) exp_q.push_back({`F_MF_LEN_M1, mfl});
      exp_q.push_back({`F_SYNC_SEL, 15'h0000, t});
      exp_q.push_back({`F_CAL_CFG, 16'h0005});
      exp_q.push_back({`F_CAL_EN, 16'h0001});
      exp_q.push_back({`F_LINK_EN, 16'h0001});
      if (fg && p) exp_q.push_back({`F_PIN_TRIG_EN, 16'h0001});
      else if (fg) begin
         exp_q.push_back({`F_SW_CAL_TRIG, 16'h0000});
         exp_q.push_back({`F_SW_CAL_TRIG, 16'h0001});
      end
   endtask
   task finish_run;
      integer n;
      n = 0;
      repeat (2) @(posedge sys_clk);
      while (!(done === 1'b1) && n < 4000) begin
         @(posedge sys_clk);
         n = n + 1;
      end
      check(done, 1, "done");
      check(busy, 0, "busy after done");
      check(wlog.size(), exp_q.size(), "write count");
      for (n = 0; n < wlog.size() && n < exp_q.size(); n = n + 1)
         check(wlog[n], exp_q[n], "write");
      check(synth_enable_strap, use_synth, "synth strap");
      check(single_ended_ref_select, use_synth && se, "ref strap");
   endtask
   task stream_fill_drain;
      integer n, k;
      reg acc;
      n = 0;
      k = 0;
      @(posedge sys_clk) rx_valid <= 1'b1;
      repeat (40) begin
         @(negedge sys_clk) acc = (rx_ready === 1'b1);
         @(posedge sys_clk) if (acc) begin
            n = n + 1;
            rx_data <= n;
         end
      end
      rx_valid <= 1'b0;
      check(n, 32, "fifo depth");
      @(posedge sys_clk) out_ready <= 1'b1;
      repeat (60) begin
         @(negedge sys_clk) if (out_valid === 1'b1) begin
            check(out_data, k, "fifo data");
            k = k + 1;
         end
      end
      check(k, 32, "drain count");
   endtask
   task scen_synth_sw;
      launch(1, 1, 1, 0, 0, 0);
      repeat (20) @(posedge sys_clk);
      check(dev_req, 0, "req before clock");
      check(busy, 1, "busy waiting for clock");
      clk_stable_in <= 1'b1;
      finish_run;
      repeat (6) @(posedge sys_clk);
      check(data_valid, 0, "valid before rx init");
      rx_init_done <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check(data_valid, 1, "valid after rx init");
      stream_fill_drain;
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      scen_synth_sw;
      launch(0, 1, 0, 1, 1, 3); // Bypass, 64b66b, pin trigger, slow device
      finish_run;
      {se, fg, trim, mfl} <= {1'b0, 1'b0, 16'h0456, 16'h000F};
      launch(1, 0, 1, 0, 0, 1); // Manual trim, no foreground cal, restarted from done
      finish_run;
      complete_run;
   end
   initial begin
      #500000;
      mismatches = mismatches + 1;
      complete_run;
   end
endmodule // bringup_sequencer_tb
